/* File: core/kbi_pkg.sv */
package kbi_pkg;
    // Bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PIN_N = 5;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_STATUS_CTRL = 8'h1A;
    localparam logic [7:0] IDX_PIN_ENABLE = 8'h1B;
    localparam logic [7:0] IDX_PORT_DIR = 8'h1C;
    localparam logic [7:0] IDX_PORT_DATA = 8'h1D;
    localparam logic [7:0] IDX_EVT_STATUS = 8'h1E;
    localparam logic [7:0] IDX_EVT_MASK = 8'h1F;
    // Status and control field positions
    localparam int F_SENSE = 0;
    localparam int F_MASK = 1;
    localparam int F_ACK = 2;
    localparam int F_PEND = 3;
    // Event status field positions
    localparam int E_LATCH = 0;
    localparam int E_ACK = 1;
    localparam int EVT_N = 2;
    // Reset values
    localparam logic [PIN_N-1:0] PIN_RST = 5'h00;
    localparam logic [EVT_N-1:0] EVT_RST = 2'h0;
    localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;
    // Interrupt vector locations, high then low byte
    localparam logic [15:0] VEC_HI_ADDR = 16'hFFDE;
    localparam logic [15:0] VEC_LO_ADDR = 16'hFFDF;
endpackage

/* File: core/kbi_keypad_latch.sv */
`timescale 1ns/10ps
// Overview of operation
// - Five pins, each with own enable
// - Enabled pin switches its pullup on
// - Latch request when enabled pin falls
// - Edge mode: no latch if another low
// - Level mode: request held while pin low
// - Level mode clears after ack and release
// - Vector fetch produces the acknowledge
// - Writing one to ack acknowledges too
// - Later falling edges latch new requests
// - Unmasked request goes to CPU vector
// - Edge mode: acknowledge clears immediately
// - Reset clears request and sense select
// - Pending flag ignores the mask
// - Enabled pin forced to input
// - Pin readable only with direction zero
// - Mask blocks CPU request; reset clears
// - Acknowledge bit always reads zero
module kbi_keypad_latch (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [kbi_pkg::ADDR_W-1:0] paddr,
    input wire logic [kbi_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [kbi_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // CPU side
    input wire logic vectorFetch,
    output logic cpuIrqReq,
    output logic irq,
    // Keypad pins
    input wire logic [kbi_pkg::PIN_N-1:0] pinIn,
    output logic [kbi_pkg::PIN_N-1:0] pinOut,
    output logic [kbi_pkg::PIN_N-1:0] pinOe,
    output logic [kbi_pkg::PIN_N-1:0] pullupEn
);
    import kbi_pkg::*;
    // Block outline:
    // - pins pass a two-stage synchroniser, then a history stage
    // - a fall is seen when the enabled set leaves the all-high state
    // - the request latch follows edge or edge-and-level rules
    // - acknowledge comes from a vector fetch or a software write
    // - CPU request is the latch gated by the mask bit
    // - a general event status and mask feed the irq output
    // Every output is a flip-flop, so all answers lag by one edge.
    // Limitation: a pin change takes two edges to reach the stage where it is judged.

    // Word index of an APB byte address
    function automatic logic [7:0] wordIdx(
        input logic [ADDR_W-1:0] a
    );
        wordIdx = {2'b00, a[ADDR_W-1:2]};
    endfunction

    // True when any enabled pin is low
    function automatic logic anyLow(
        input logic [PIN_N-1:0] lvl,
        input logic [PIN_N-1:0] en
    );
        anyLow = |(~lvl & en);
    endfunction

    // Synchroniser and history
    logic [PIN_N-1:0] pinMeta_r; // First stage, read only by second
    logic [PIN_N-1:0] pinSync_r; // Second stage
    logic [PIN_N-1:0] pinPrev_r; // Last synchronised level

    // Software-visible state
    logic [PIN_N-1:0] pinEnable_r; // Source enables
    logic senseSelect_r; // One: edge and level
    logic requestMask_r; // Blocks CPU request
    logic [PIN_N-1:0] portDir_r; // One drives pin
    logic [PIN_N-1:0] portData_r; // Output latch
    logic [EVT_N-1:0] evtStatus_r; // Sticky events
    logic [EVT_N-1:0] evtMask_r; // Event enables

    // Request latch state
    logic request_r; // Latched keypad request
    logic ackSeen_r; // Level mode ack pending release

    // Bus decode
    logic setupPhase;
    logic wrTake;
    logic wrByte;
    logic [7:0] accIdx;
    logic addrOk;

    // Request evaluation
    logic lowNow;
    logic lowBefore;
    logic fallEvt;
    logic ackPulse;
    logic request_nxt;
    logic ackSeen_nxt;

    // Bus decode is purely combinational from the live bus signals.
    // A write is only honoured at the edge where pready is high.
    // Byte lane zero carries all register fields.
    assign accIdx = wordIdx(paddr);
    assign setupPhase = psel & ~penable;
    // Write lands only at the access edge the slave answers on
    assign wrTake = psel & penable & pready & pwrite & ce;
    assign wrByte = wrTake & pstrb[0];
    assign addrOk = (accIdx >= IDX_STATUS_CTRL)
        && (accIdx <= IDX_EVT_MASK);

    // Reset loads all-high, so a pin held low through reset looks like
    // a fresh fall once it reaches the second stage, two edges after it.
    // Only the second stage reads the first; nothing else may.
    // Synchronise pins to the bus clock
    always_ff @(posedge clk) begin
        if (rst) begin
            pinMeta_r <= ~PIN_RST;
            pinSync_r <= ~PIN_RST;
            pinPrev_r <= ~PIN_RST;
        end else if (ce) begin
            pinMeta_r <= pinIn;
            pinSync_r <= pinMeta_r;
            pinPrev_r <= pinSync_r;
        end
    end

    // Enable masks both the present and the past level.
    // Level tests use only synchronised copies
    assign lowNow = anyLow(pinSync_r, pinEnable_r);
    assign lowBefore = anyLow(pinPrev_r, pinEnable_r);
    // Fall only counts from the all-high state
    assign fallEvt = lowNow & ~lowBefore;

    // Acknowledge from either source
    assign ackPulse = vectorFetch
        | (wrByte && accIdx == IDX_STATUS_CTRL
           && pwdata[F_ACK]);

    // Edge mode keeps no ack memory; a fall in the same cycle as
    // an acknowledge wins, so a key pressed during the clear is
    // never lost. Level mode remembers an ack given while a
    // request stands and releases the latch once every enabled
    // pin reads high again. An ack with no request is dropped,
    // which keeps a stray write from pre-clearing a later press.
    // Next request and ack memory
    always_comb begin
        request_nxt = request_r;
        ackSeen_nxt = ackSeen_r;
        if (!senseSelect_r) begin
            // Edge only: ack clears now, new fall wins
            ackSeen_nxt = 1'b0;
            if (ackPulse) begin
                request_nxt = 1'b0;
            end
            if (fallEvt) begin
                request_nxt = 1'b1;
            end
        end else begin
            // Level mode: two conditions in any order
            if (ackPulse && request_r) begin
                ackSeen_nxt = 1'b1;
            end
            if (ackSeen_nxt && !lowNow) begin
                request_nxt = 1'b0;
                ackSeen_nxt = 1'b0;
            end
            if (fallEvt) begin
                request_nxt = 1'b1;
                ackSeen_nxt = 1'b0;
            end else if (lowNow && !ackSeen_nxt) begin
                request_nxt = 1'b1;
            end
        end
    end

    // The latch and its ack memory share one enable and reset.
    // Freezing with ce low holds both, so no ack is half taken.
    // Request latch; reset wins even with a pin low
    always_ff @(posedge clk) begin
        if (rst) begin
            request_r <= 1'b0;
            ackSeen_r <= 1'b0;
        end else if (ce) begin
            request_r <= request_nxt;
            ackSeen_r <= ackSeen_nxt;
        end
    end

    // Mask and sense bits are plain storage; the ack bit has no
    // storage at all, which is why it can only ever read zero.
    // Writes need pstrb[0], the byte that holds the fields.
    // Status and control register
    always_ff @(posedge clk) begin
        if (rst) begin
            senseSelect_r <= 1'b0;
            requestMask_r <= 1'b0;
        end else if (wrByte && accIdx == IDX_STATUS_CTRL) begin
            senseSelect_r <= pwdata[F_SENSE];
            requestMask_r <= pwdata[F_MASK];
        end
    end

    // Enabling a pin while it is already low does not latch in edge mode, as the
    // history is judged against the same enable set; software that
    // wants such a pin reported there must release it first; level mode latches it.
    // Pin enable register
    always_ff @(posedge clk) begin
        if (rst) begin
            pinEnable_r <= PIN_RST;
        end else if (wrByte && accIdx == IDX_PIN_ENABLE) begin
            pinEnable_r <= pwdata[PIN_N-1:0];
        end
    end

    // Direction one drives the pin unless its enable is set.
    // Data latch keeps its value across direction changes.
    // Port direction and data latch
    always_ff @(posedge clk) begin
        if (rst) begin
            portDir_r <= PIN_RST;
            portData_r <= PIN_RST;
        end else if (wrByte) begin
            if (accIdx == IDX_PORT_DIR) begin
                portDir_r <= pwdata[PIN_N-1:0];
            end
            if (accIdx == IDX_PORT_DATA) begin
                portData_r <= pwdata[PIN_N-1:0];
            end
        end
    end

    // Drivers lag the registers by one edge; pullups come on one edge after
    // the enable is written, so a fresh pin may float for a
    // few cycles and raise a false request that software acks.
    // Pin drivers, all registered
    always_ff @(posedge clk) begin
        if (rst) begin
            pinOut <= PIN_RST;
            pinOe <= PIN_RST;
            pullupEn <= PIN_RST;
        end else if (ce) begin
            pinOut <= portData_r;
            // Enable overrides direction, pin stays input
            pinOe <= portDir_r & ~pinEnable_r;
            pullupEn <= pinEnable_r;
        end
    end

    // Event mask selects which sticky bits reach irq.
    // Event mask register
    always_ff @(posedge clk) begin
        if (rst) begin
            evtMask_r <= EVT_RST;
        end else if (wrByte && accIdx == IDX_EVT_MASK) begin
            evtMask_r <= pwdata[EVT_N-1:0];
        end
    end

    // Latch bit marks each new request, ack bit each acknowledge.
    // Clear is write-one; an event in the same cycle keeps its bit.
    // Sticky events; a new event beats a same-cycle clear
    always_ff @(posedge clk) begin
        if (rst) begin
            evtStatus_r <= EVT_RST;
        end else if (ce) begin
            if (wrByte && accIdx == IDX_EVT_STATUS) begin
                evtStatus_r <= evtStatus_r & ~pwdata[EVT_N-1:0];
            end
            if (request_nxt && !request_r) begin
                evtStatus_r[E_LATCH] <= 1'b1;
            end
            if (ackPulse) begin
                evtStatus_r[E_ACK] <= 1'b1;
            end
        end
    end

    // cpuIrqReq goes to the CPU vector logic; irq is the general
    // level line for the event status bits, gated by evtMask.
    // Interrupt outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            cpuIrqReq <= 1'b0;
            irq <= 1'b0;
        end else if (ce) begin
            // Mask gates CPU path only, flag still shows
            cpuIrqReq <= request_nxt & ~requestMask_r;
            irq <= |(evtStatus_r & evtMask_r);
        end
    end

    // Read data is taken at the setup edge, so a value that changes
    // in the access cycle is reported as it stood one edge before.
    // Unmapped indices answer with pslverr and read zero.
    // APB answer: data captured in setup, ready in access
    // Costs one wait-free access but keeps outputs registered
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= RD_ZERO;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= setupPhase;
            pslverr <= setupPhase & ~addrOk;
            prdata <= RD_ZERO;
            if (setupPhase && !pwrite) begin
                case (accIdx)
                    IDX_STATUS_CTRL: begin
                        // Ack bit reads zero; flag ignores mask
                        prdata[F_PEND] <= request_r;
                        prdata[F_ACK] <= 1'b0;
                        prdata[F_MASK] <= requestMask_r;
                        prdata[F_SENSE] <= senseSelect_r;
                    end
                    IDX_PIN_ENABLE: begin
                        prdata[PIN_N-1:0] <= pinEnable_r;
                    end
                    IDX_PORT_DIR: begin
                        prdata[PIN_N-1:0] <= portDir_r;
                    end
                    IDX_PORT_DATA: begin
                        // Pin level shows only where direction is 0
                        prdata[PIN_N-1:0] <= (pinSync_r & ~portDir_r)
                            | (portData_r & portDir_r);
                    end
                    IDX_EVT_STATUS: begin
                        prdata[EVT_N-1:0] <= evtStatus_r;
                    end
                    IDX_EVT_MASK: begin
                        prdata[EVT_N-1:0] <= evtMask_r;
                    end
                    default: begin
                        prdata <= RD_ZERO;
                    end
                endcase
            end
        end
    end
endmodule // kbi_keypad_latch

/* File: sim/kbi_keypad_latch_chk.sv */
`timescale 1ns/10ps
module kbi_keypad_latch_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [kbi_pkg::ADDR_W-1:0] paddr,
    input wire logic [kbi_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [kbi_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic vectorFetch,
    input wire logic cpuIrqReq,
    input wire logic [kbi_pkg::PIN_N-1:0] pinIn,
    input wire logic [kbi_pkg::PIN_N-1:0] pinOe,
    input wire logic [kbi_pkg::PIN_N-1:0] pullupEn
);
    import kbi_pkg::*;
    logic shMask_r; // Shadow of the mask bit
    logic shSense_r; // Shadow of the sense select bit
    wire wrSc = psel && penable && pready && pwrite && pstrb[0]
        && paddr == 8'h68;
    wire ackC = vectorFetch || (wrSc && pwdata[F_ACK]);
    wire lowE = |(~pinIn & pullupEn); // Some enabled pin low
    // Track control bits as software writes them
    always_ff @(posedge clk) begin
        if (rst) begin
            shMask_r <= 1'b0;
            shSense_r <= 1'b0;
        end else if (wrSc) begin
            shMask_r <= pwdata[F_MASK];
            shSense_r <= pwdata[F_SENSE];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // A pin enabled while already low is no fall; enables must hold
    sequence s_fall; !lowE ##1 (lowE && $stable(pullupEn)); endsequence
    sequence s_quiet;
        (!ackC && !shMask_r && $stable(pullupEn))[*4];
    endsequence
    a_fall_latches: assert property (s_fall ##0 s_quiet |-> ##[0:1] cpuIrqReq)
        else $error("no request after pin fall");
    a_edge_ack_clr: assert property (!shSense_r && ackC |-> ##[1:3] !cpuIrqReq)
        else $error("acknowledge did not clear request");
    a_level_holds: assert property (shSense_r && !shMask_r && $past(cpuIrqReq)
        && lowE && $past(lowE,2) && $past(lowE,3) |-> cpuIrqReq)
        else $error("request dropped while pin low");
    a_no_relatch: assert property (!shSense_r && $rose(cpuIrqReq)
        |-> !$past(lowE,4) || !$past(lowE,5))
        else $error("request without all pins high first");
    a_masked_quiet: assert property (shMask_r && $past(shMask_r) |-> !cpuIrqReq)
        else $error("masked request reached cpu");
    a_ack_reads_zero: assert property (pready && !pwrite && paddr == 8'h68 |-> !prdata[F_ACK])
        else $error("acknowledge bit read as one");
    a_oe_yields: assert property ((pinOe & pullupEn) == 5'h00)
        else $error("enabled pin driven");
    a_reset_clears: assert property (disable iff (1'b0) rst |=> !cpuIrqReq && pullupEn == 5'h00)
        else $error("reset left request or enables");
endmodule // kbi_keypad_latch_chk
bind kbi_keypad_latch kbi_keypad_latch_chk chk (.clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .vectorFetch,
    .cpuIrqReq, .pinIn, .pinOe, .pullupEn);

/* File: sim/kbi_keypad_model.sv */
`timescale 1ns/10ps
module kbi_keypad_model (
    input wire logic clk,
    input wire logic [kbi_pkg::PIN_N-1:0] press,
    input wire logic [kbi_pkg::PIN_N-1:0] pinOut,
    input wire logic [kbi_pkg::PIN_N-1:0] pinOe,
    input wire logic [kbi_pkg::PIN_N-1:0] pullupEn,
    output logic [kbi_pkg::PIN_N-1:0] pinLvl
);
    import kbi_pkg::*;
    logic flt_r = 1'b0; // Pattern seen on a floating pin
    always_ff @(posedge clk) flt_r <= ~flt_r;
    // Driver wins, then a closed switch, then the pullup, else it floats
    always_comb begin
        for (int i = 0; i < PIN_N; i++) begin
            if (pinOe[i]) pinLvl[i] = pinOut[i];
            else if (press[i]) pinLvl[i] = 1'b0;
            else pinLvl[i] = pullupEn[i] | flt_r;
        end
    end
endmodule // kbi_keypad_model

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    import kbi_pkg::*;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, vectorFetch = 1'b0, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, d;
    logic [3:0] pstrb = 4'hF;
    logic [4:0] press = 5'h00, pinOut, pinOe, pullupEn, pinLvl;
    logic pready, pslverr, cpuIrqReq, irq;
    integer seed = 32'h894A6C4E;
    int fails = 0, num_checks = 0, k, p;
    always #5 clk = ~clk;
    kbi_keypad_latch dut (.clk, .rst, .ce(1'b1), .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .vectorFetch,
        .cpuIrqReq, .irq, .pinIn(pinLvl), .pinOut, .pinOe, .pullupEn);
    kbi_keypad_model pad (.clk, .press, .pinOut, .pinOe, .pullupEn, .pinLvl);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task end_sim;
        if (fails == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // One APB transfer, held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        for (k = 0; pready !== 1'b1 && k < 50; k++) @(posedge clk);
        if (k == 50) fails++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task fetch; // One cycle vector fetch pulse
        vectorFetch <= 1'b1;
        @(posedge clk);
        vectorFetch <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // Expected status word from pending, mask and sense
    function logic [31:0] st(input logic pd, input logic m, input logic s);
        return {28'h0, pd, 1'b0, m, s};
    endfunction
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rdc(8'h68, st(0, 0, 0));
        rdc(8'h6C, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, 8'h6C, 32'h1F);
        repeat (4) @(posedge clk); // Let floating pins settle high
        apb(1'b1, 8'h68, 32'h4);
        chk({27'h0, pullupEn}, 32'h1F);
        // Edge mode, random pin, second pin pressed while first held
        for (int n = 0; n < 6; n++) begin
            p = {$random(seed)} % 5;
            press <= 5'h01 << p;
            repeat (6) @(posedge clk);
            chk({31'h0, cpuIrqReq}, 32'h1);
            rdc(8'h68, st(1, 0, 0));
            apb(1'b1, 8'h68, 32'h4);
            rdc(8'h68, st(0, 0, 0));
            press <= press | (5'h01 << ((p + 1) % 5));
            repeat (6) @(posedge clk);
            rdc(8'h68, st(0, 0, 0));
            press <= 5'h00;
            repeat (4) @(posedge clk);
        end
        // Masked request, event status and interrupt line
        apb(1'b1, 8'h68, 32'h2);
        press <= 5'h01;
        repeat (6) @(posedge clk);
        chk({31'h0, cpuIrqReq}, 32'h0);
        rdc(8'h68, st(1, 1, 0));
        apb(1'b1, 8'h7C, 32'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, 8'h7C, 32'h0);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        fetch;
        rdc(8'h68, st(0, 1, 0));
        press <= 5'h00;
        apb(1'b1, 8'h78, 32'h3);
        rdc(8'h78, 32'h0);
        apb(1'b1, 8'h68, 32'h0);
        // Level mode: ack then release, release then ack
        apb(1'b1, 8'h68, 32'h1);
        press <= 5'h10;
        repeat (6) @(posedge clk);
        fetch;
        rdc(8'h68, st(1, 0, 1));
        press <= 5'h00;
        repeat (6) @(posedge clk);
        rdc(8'h68, st(0, 0, 1));
        press <= 5'h04;
        repeat (6) @(posedge clk);
        press <= 5'h00;
        repeat (6) @(posedge clk);
        rdc(8'h68, st(1, 0, 1));
        apb(1'b1, 8'h68, 32'h5);
        rdc(8'h68, st(0, 0, 1));
        // Reset with a pin held low
        press <= 5'h04;
        repeat (6) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(8'h68, st(0, 0, 0));
        // Direction override and pin read back
        apb(1'b1, 8'h6C, 32'h1F);
        apb(1'b1, 8'h70, 32'h1F);
        chk({27'h0, pinOe}, 32'h0);
        d = $random(seed) & 32'h1F;
        apb(1'b1, 8'h6C, 32'h0);
        apb(1'b1, 8'h74, d);
        repeat (2) @(posedge clk);
        chk({27'h0, pinOe}, 32'h1F);
        chk({27'h0, pinOut}, d);
        apb(1'b1, 8'h70, 32'h0);
        apb(1'b1, 8'h6C, 32'h1F);
        press <= 5'h02;
        repeat (4) @(posedge clk);
        rdc(8'h74, 32'h1D);
        end_sim;
    end
    initial begin
        #100000;
        fails++;
        end_sim;
    end
endmodule // tb_top
